// file: rtl/awpl_wake_regs.v
// acpi wake and power-loss register bank behind an axi4-lite slave
// assumes event and strap pins are asynchronous; axi is on CORE_CLK
`timescale 1ns/1ps
`default_nettype none
`include "awpl_regs.vh"

module awpl_wake_regs
(
   input  wire                       CORE_CLK,
   input  wire                       RST_N,
   // axi4-lite slave
   input  wire [`AWPL_ADDR_W-1:0]    S_AXI_AWADDR,
   input  wire [2:0]                 S_AXI_AWPROT,
   input  wire                       S_AXI_AWVALID,
   output wire                       S_AXI_AWREADY,
   input  wire [31:0]                S_AXI_WDATA,
   input  wire [3:0]                 S_AXI_WSTRB,
   input  wire                       S_AXI_WVALID,
   output wire                       S_AXI_WREADY,
   output reg  [1:0]                 S_AXI_BRESP,
   output reg                        S_AXI_BVALID,
   input  wire                       S_AXI_BREADY,
   input  wire [`AWPL_ADDR_W-1:0]    S_AXI_ARADDR,
   input  wire [2:0]                 S_AXI_ARPROT,
   input  wire                       S_AXI_ARVALID,
   output wire                       S_AXI_ARREADY,
   output reg  [31:0]                S_AXI_RDATA,
   output reg  [1:0]                 S_AXI_RRESP,
   output reg                        S_AXI_RVALID,
   input  wire                       S_AXI_RREADY,
   // asynchronous inputs
   input  wire                       BUS_RST_N,
   input  wire                       THERMAL_SHUTDOWN,
   input  wire                       POWER_SWITCH_INPUT,
   input  wire                       MOUSE_WAKE,
   input  wire                       KEYBOARD_WAKE,
   input  wire                       STANDBY_RETURN,
   input  wire                       POWER_FAIL,
   input  wire                       SYS_POWER_ON,
   // outputs
   output reg                        WAKE_REQUEST,
   output reg                        RECOVERY_POWER_ON,
   output reg                        CHASSIS_INTRUSION_CLEAR,
   output reg                        KBD_WAKE_ANY_KEY,
   output reg                        MOUSE_WAKE_SELECT_C,
   output reg  [4:0]                 GPIO_BUS_RESET_BLOCK,
   output reg                        GPIO2_UPPER_PINS_RSM_SEL
);

   localparam NSYNC = 8;

   // pin order in the synchroniser vector
   localparam P_BUSRST = 0;
   localparam P_THERM  = 1;
   localparam P_PSW    = 2;
   localparam P_MOUSE  = 3;
   localparam P_KBD    = 4;
   localparam P_SBRET  = 5;
   localparam P_PFAIL  = 6;
   localparam P_SYSON  = 7;

   // write channel states, one-hot
   localparam W_IDLE = 2'b01;
   localparam W_RESP = 2'b10;

   reg  [NSYNC-1:0]         sync_a;
   reg  [NSYNC-1:0]         sync_b;
   reg  [NSYNC-1:0]         sync_d;
   wire [NSYNC-1:0]         rise;

   reg  [7:0]               status;
   reg  [7:0]               plctrl;
   reg  [7:0]               gpiorst;
   reg  [7:0]               misc;
   reg                      prev_on;

   reg  [1:0]               wstate;
   reg                      aw_held;
   reg                      w_held;
   reg  [`AWPL_ADDR_W-1:0]  aw_addr;
   reg  [7:0]               w_byte;
   reg                      w_lane;

   wire                     aw_fire;
   wire                     w_fire;
   wire                     ar_fire;
   wire                     wr_go;
   wire [`AWPL_ADDR_W-1:0]  wr_addr;
   wire [7:0]               wr_data;
   wire                     wr_lane;
   wire                     bus_reset;

   reg  [7:0]               clr_mask;
   reg  [7:0]               set_mask;
   reg  [7:0]               next_status;
   reg  [7:0]               rd_byte;
   reg                      rd_hit;
   reg                      wr_hit;
   reg                      next_power_on;
   wire                     wake_any;

   // two flip-flops before any logic sees a pin
   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         sync_a <= 8'h01;
         sync_b <= 8'h01;
         sync_d <= 8'h01;
      end
      else
      begin
         sync_a <= {SYS_POWER_ON, POWER_FAIL, STANDBY_RETURN, KEYBOARD_WAKE,
                    MOUSE_WAKE, POWER_SWITCH_INPUT, THERMAL_SHUTDOWN, BUS_RST_N};
         sync_b <= sync_a;
         sync_d <= sync_b;
      end
   end

   assign rise = sync_b & ~sync_d;

   // bus reset acts on its asserted level, resetting only the bus-powered bits
   assign bus_reset = ~sync_b[P_BUSRST];

   assign wake_any = rise[P_PSW] | rise[P_MOUSE] | rise[P_KBD];

   // ---------------- axi write channel ----------------
   // a single write in flight keeps decode simple; ready drops while answering
   assign aw_fire       = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_fire        = S_AXI_WVALID & S_AXI_WREADY;
   assign S_AXI_AWREADY = wstate[0] & ~aw_held;
   assign S_AXI_WREADY  = wstate[0] & ~w_held;

   assign wr_go   = wstate[0] & (aw_held | aw_fire) & (w_held | w_fire);
   assign wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
   assign wr_data = w_held ? w_byte : S_AXI_WDATA[7:0];
   assign wr_lane = w_held ? w_lane : S_AXI_WSTRB[0];

   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         wstate       <= W_IDLE;
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= {`AWPL_ADDR_W{1'b0}};
         w_byte       <= 8'h00;
         w_lane       <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `AWPL_RESP_OKAY;
      end
      else
      begin
         case (wstate)
            W_IDLE:
            begin
               if (wr_go)
               begin
                  aw_held      <= 1'b0;
                  w_held       <= 1'b0;
                  S_AXI_BVALID <= 1'b1;
                  S_AXI_BRESP  <= wr_hit ? `AWPL_RESP_OKAY : `AWPL_RESP_SLVERR;
                  wstate       <= W_RESP;
               end
               else
               begin
                  if (aw_fire)
                  begin
                     aw_held <= 1'b1;
                     aw_addr <= S_AXI_AWADDR;
                  end
                  if (w_fire)
                  begin
                     w_held <= 1'b1;
                     w_byte <= S_AXI_WDATA[7:0];
                     w_lane <= S_AXI_WSTRB[0];
                  end
               end
            end
            W_RESP:
            begin
               if (S_AXI_BREADY)
               begin
                  S_AXI_BVALID <= 1'b0;
                  wstate       <= W_IDLE;
               end
            end
            default:
            begin
               wstate <= W_IDLE;
            end
         endcase
      end
   end

   // write address decode
   always @*
   begin
      wr_hit = 1'b0;
      if (wr_addr == {`AWPL_IDX_STATUS, 2'b00})
         wr_hit = 1'b1;
      else if (wr_addr == {`AWPL_IDX_PLCTRL, 2'b00})
         wr_hit = 1'b1;
      else if (wr_addr == {`AWPL_IDX_GPIORST, 2'b00})
         wr_hit = 1'b1;
      else if (wr_addr == {`AWPL_IDX_MISC, 2'b00})
         wr_hit = 1'b1;
   end

   // ---------------- axi read channel ----------------
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign ar_fire       = S_AXI_ARVALID & S_AXI_ARREADY;

   always @*
   begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      if (S_AXI_ARADDR == {`AWPL_IDX_STATUS, 2'b00})
      begin
         rd_byte = status;
         if (!plctrl[`AWPL_PL_EN])
            rd_byte[`AWPL_ST_PLOSS] = 1'b0;
      end
      else if (S_AXI_ARADDR == {`AWPL_IDX_PLCTRL, 2'b00})
         rd_byte = plctrl;
      else if (S_AXI_ARADDR == {`AWPL_IDX_GPIORST, 2'b00})
         rd_byte = gpiorst;
      else if (S_AXI_ARADDR == {`AWPL_IDX_MISC, 2'b00})
         rd_byte = misc;
      else
         rd_hit = 1'b0;
   end

   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= `AWPL_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA  <= {24'h000000, rd_byte};
         S_AXI_RRESP  <= rd_hit ? `AWPL_RESP_OKAY : `AWPL_RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ---------------- event status ----------------
   always @*
   begin
      clr_mask = 8'h00;
      if (ar_fire && S_AXI_ARADDR == {`AWPL_IDX_STATUS, 2'b00})
         clr_mask = 8'h1F;
      set_mask = 8'h00;
      set_mask[`AWPL_ST_THERM] = rise[P_THERM];
      set_mask[`AWPL_ST_PSW]   = rise[P_PSW];
      set_mask[`AWPL_ST_MOUSE] = rise[P_MOUSE];
      set_mask[`AWPL_ST_KBD]   = rise[P_KBD];
      next_status = (status & ~clr_mask) | set_mask;
      // power-loss outcome: 0 when power came back on, 1 when left off
      if (rise[P_SBRET] && plctrl[`AWPL_PL_EN])
         next_status[`AWPL_ST_PLOSS] = ~next_power_on;
      next_status[7:5] = 3'b000;
   end

   // recovery decision on return of standby power
   always @*
   begin
      case (plctrl[`AWPL_PL_POL_HI:`AWPL_PL_POL_LO])
         `AWPL_POL_OFF:  next_power_on = 1'b0;
         `AWPL_POL_ON:   next_power_on = 1'b1;
         `AWPL_POL_PREV: next_power_on = prev_on;
         default:        next_power_on = ~misc[`AWPL_MC_LAST_OFF];
      endcase
   end

   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         status            <= `AWPL_RST_STATUS;
         prev_on           <= 1'b0;
         RECOVERY_POWER_ON <= 1'b0;
         WAKE_REQUEST      <= 1'b0;
      end
      else
      begin
         status <= next_status;
         // the pre-loss state freezes once power has failed
         if (!sync_b[P_PFAIL])
            prev_on <= sync_b[P_SYSON];
         RECOVERY_POWER_ON <= rise[P_SBRET] & plctrl[`AWPL_PL_EN] & next_power_on;
         WAKE_REQUEST      <= wake_any & plctrl[`AWPL_PL_HUNT];
      end
   end

   // ---------------- control registers ----------------
   // battery bits survive the bus reset; only keyboard option and hunting follow it
   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         plctrl    <= `AWPL_RST_PLCTRL;
         gpiorst   <= `AWPL_RST_GPIORST;
         misc      <= `AWPL_RST_MISC;
      end
      else
      begin
         if (wr_go && wr_lane && wr_addr == {`AWPL_IDX_PLCTRL, 2'b00})
         begin
            plctrl[7:5] <= wr_data[7:5];
            plctrl[3:2] <= wr_data[3:2];
         end
         else if (wr_go && wr_lane && wr_addr == {`AWPL_IDX_GPIORST, 2'b00})
         begin
            gpiorst[7:2] <= wr_data[7:2];
         end
         else if (wr_go && wr_lane && wr_addr == {`AWPL_IDX_MISC, 2'b00})
         begin
            misc[`AWPL_MC_MSEL_C]   <= wr_data[`AWPL_MC_MSEL_C];
            misc[`AWPL_MC_LAST_OFF] <= wr_data[`AWPL_MC_LAST_OFF];
            misc[`AWPL_MC_KEEP_HI:`AWPL_MC_KEEP_LO] <=
               wr_data[`AWPL_MC_KEEP_HI:`AWPL_MC_KEEP_LO];
         end
         // a captured wake disarms hunting even against a same-cycle write
         if (wake_any)
            plctrl[`AWPL_PL_HUNT] <= 1'b0;
         if (bus_reset)
         begin
            plctrl[`AWPL_PL_KBD_ANY] <= 1'b0;
            plctrl[`AWPL_PL_HUNT]    <= 1'b0;
         end
      end
   end

   // clear strobe reads back as zero; it only lives as a one-cycle pulse
   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
         CHASSIS_INTRUSION_CLEAR <= 1'b0;
      else
         CHASSIS_INTRUSION_CLEAR <= wr_go & wr_lane
                                    & (wr_addr == {`AWPL_IDX_MISC, 2'b00})
                                    & wr_data[`AWPL_MC_CASE_CLR];
   end

   // ---------------- outputs to the rest of the chip ----------------
   always @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         KBD_WAKE_ANY_KEY         <= 1'b0;
         MOUSE_WAKE_SELECT_C      <= 1'b0;
         GPIO_BUS_RESET_BLOCK     <= 5'h00;
         GPIO2_UPPER_PINS_RSM_SEL <= 1'b0;
      end
      else
      begin
         KBD_WAKE_ANY_KEY         <= plctrl[`AWPL_PL_KBD_ANY];
         MOUSE_WAKE_SELECT_C      <= misc[`AWPL_MC_MSEL_C];
         GPIO_BUS_RESET_BLOCK     <= gpiorst[`AWPL_GR_BLK_HI:`AWPL_GR_BLK_LO];
         GPIO2_UPPER_PINS_RSM_SEL <= gpiorst[`AWPL_GR_UPPER_RSM];
      end
   end

endmodule
`default_nettype wire

// file: rtl/awpl_regs.vh
// register map, field positions, reset values and codes of the acpi wake block
// assumes a 32-bit axi4-lite bus with one aligned word per register
`ifndef AWPL_REGS_VH
`define AWPL_REGS_VH

// register indices; byte address is four times the index
`define AWPL_IDX_STATUS        10'h0E3
`define AWPL_IDX_PLCTRL        10'h0E4
`define AWPL_IDX_GPIORST       10'h0E5
`define AWPL_IDX_MISC          10'h0E6
`define AWPL_ADDR_W            12

// reset values
`define AWPL_RST_STATUS        8'h08
`define AWPL_RST_PLCTRL        8'h00
`define AWPL_RST_GPIORST       8'h00
`define AWPL_RST_MISC          8'h1C

// wake_event_status fields
`define AWPL_ST_PLOSS          4
`define AWPL_ST_THERM          3
`define AWPL_ST_PSW            2
`define AWPL_ST_MOUSE          1
`define AWPL_ST_KBD            0

// power_loss_wake_control fields
`define AWPL_PL_EN             7
`define AWPL_PL_POL_HI         6
`define AWPL_PL_POL_LO         5
`define AWPL_PL_KBD_ANY        3
`define AWPL_PL_HUNT           2

// gpio_reset_source_select fields
`define AWPL_GR_BLK_HI         7
`define AWPL_GR_BLK_LO         3
`define AWPL_GR_UPPER_RSM      2

// misc_wake_case_control fields
`define AWPL_MC_MSEL_C         7
`define AWPL_MC_CASE_CLR       5
`define AWPL_MC_LAST_OFF       4
`define AWPL_MC_KEEP_HI        3
`define AWPL_MC_KEEP_LO        1

// recovery policy codes
`define AWPL_POL_OFF           2'h0
`define AWPL_POL_ON            2'h1
`define AWPL_POL_PREV          2'h2
`define AWPL_POL_FLAG          2'h3

// axi responses
`define AWPL_RESP_OKAY         2'h0
`define AWPL_RESP_SLVERR       2'h2

`endif

// file: tb/awpl_checker.sv
// checker: bus handshake and register-to-pin timing of the wake register bank
// assumes it is bound to awpl_wake_regs with both write halves offered together
`timescale 1ns/1ps
`default_nettype none
module awpl_checker
(
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0]  S_AXI_WSTRB,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        CHASSIS_INTRUSION_CLEAR,
   input wire logic        MOUSE_WAKE_SELECT_C,
   input wire logic [4:0]  GPIO_BUS_RESET_BLOCK,
   input wire logic        GPIO2_UPPER_PINS_RSM_SEL
);
   // a byte lands only when both halves go in one edge with the low strobe set
   wire wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
                && S_AXI_WSTRB[0];
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   chk_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address accepted while read data pending");
   chk_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while response pending");
   chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped before taken");
   chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
      else $error("read data dropped before taken");
   chk_gpio_follow: assert property (
      wr_go && S_AXI_AWADDR == 12'h394 |-> ##2
      {GPIO_BUS_RESET_BLOCK, GPIO2_UPPER_PINS_RSM_SEL} == $past(S_AXI_WDATA[7:2], 2))
      else $error("gpio reset controls do not follow register");
   chk_msel_follow: assert property (
      wr_go && S_AXI_AWADDR == 12'h398 |-> ##2 MOUSE_WAKE_SELECT_C == $past(S_AXI_WDATA[7], 2))
      else $error("mouse selector does not follow register");
   chk_case_clear: assert property (
      wr_go && S_AXI_AWADDR == 12'h398 && S_AXI_WDATA[5] |-> ##[1:3] CHASSIS_INTRUSION_CLEAR)
      else $error("intrusion clear strobe missing");
   chk_case_pulse: assert property (
      $rose(CHASSIS_INTRUSION_CLEAR) |=> !CHASSIS_INTRUSION_CLEAR)
      else $error("intrusion clear strobe longer than one cycle");
endmodule
bind awpl_wake_regs awpl_checker u_chk
(
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .CHASSIS_INTRUSION_CLEAR(CHASSIS_INTRUSION_CLEAR), .MOUSE_WAKE_SELECT_C(MOUSE_WAKE_SELECT_C),
   .GPIO_BUS_RESET_BLOCK(GPIO_BUS_RESET_BLOCK),
   .GPIO2_UPPER_PINS_RSM_SEL(GPIO2_UPPER_PINS_RSM_SEL)
);
`default_nettype wire

// file: tb/awpl_host_model.sv
// host model: axi4-lite master making one register access at a time
// assumes no fixed answer latency; only the bench watchdog ends a wait
`timescale 1ns/1ps
`default_nettype none
module awpl_host_model
(
   input  wire logic        clk,
   output var  logic [11:0] awaddr,
   output var  logic        awvalid,
   output var  logic [31:0] wdata,
   output var  logic [3:0]  wstrb,
   output var  logic        wvalid,
   output var  logic        bready,
   input  wire logic        awready,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output var  logic [11:0] araddr,
   output var  logic        arvalid,
   output var  logic        rready,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid
);
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
                     output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // each half is released at its own edge; the slave may take them apart
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (awvalid && !awready || wvalid && !wready);
      while (!bvalid)
         @(posedge clk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
         @(posedge clk);
      while (!arready);
      arvalid <= 1'b0;
      while (!rvalid)
         @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the acpi wake register bank
// assumes the host model for bus cycles and the bound checker for timing
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk, rst_n, bus_rst_n, stby, pfail, syson;
   logic [3:0]  ev;
   wire  [11:0] awaddr, araddr;
   wire  [31:0] wdata, rdata;
   wire  [3:0]  wstrb;
   wire  [1:0]  bresp, rresp;
   wire         awvalid, awready, wvalid, wready, bvalid, bready;
   wire         arvalid, arready, rvalid, rready, wake, rec_on, case_clr, any_key, msel, rsm;
   wire  [4:0]  gblk;
   logic [31:0] d;
   logic [1:0]  r;
   int          n_fail = 0, checked = 0, n_wake = 0, n_rec = 0, n_clr = 0;
   awpl_wake_regs dut
   (
      .CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BUS_RST_N(bus_rst_n),
      .THERMAL_SHUTDOWN(ev[3]), .POWER_SWITCH_INPUT(ev[2]), .MOUSE_WAKE(ev[1]),
      .KEYBOARD_WAKE(ev[0]), .STANDBY_RETURN(stby), .POWER_FAIL(pfail), .SYS_POWER_ON(syson),
      .WAKE_REQUEST(wake), .RECOVERY_POWER_ON(rec_on), .CHASSIS_INTRUSION_CLEAR(case_clr),
      .KBD_WAKE_ANY_KEY(any_key), .MOUSE_WAKE_SELECT_C(msel), .GPIO_BUS_RESET_BLOCK(gblk),
      .GPIO2_UPPER_PINS_RSM_SEL(rsm)
   );
   awpl_host_model host
   (
      .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .bready(bready), .awready(awready), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .rready(rready),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
   );
   always @(posedge clk) if (wake) n_wake++;
   always @(posedge clk) if (rec_on) n_rec++;
   always @(posedge clk) if (case_clr) n_clr++;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      host.rd(a, d, r);
      check(d, {24'h0, e});
      check(32'(r), 32'h0);
   endtask
   task automatic wr_ok(input logic [11:0] a, input logic [7:0] v);
      host.wr(a, v, 4'hF, r);
      check(32'(r), 32'h0);
   endtask
   // pins pass a two-flop synchroniser, so each level is held three edges
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      ev <= m;
      repeat (3) @(posedge clk);
      ev <= 4'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic power_loss;
      @(posedge clk);
      pfail <= 1'b1;
      syson <= 1'b0;
      repeat (4) @(posedge clk);
      stby <= 1'b1;
      repeat (8) @(posedge clk);
      {stby, pfail, syson} <= 3'b001;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_reset;
      check(32'({wake, rec_on, case_clr, any_key, msel, gblk, rsm}), 32'h0);
      rd_chk(12'h38C, 8'h08);
      rd_chk(12'h38C, 8'h00);
      rd_chk(12'h390, 8'h00);
      rd_chk(12'h394, 8'h00);
      rd_chk(12'h398, 8'h1C);
      host.rd(12'h3FC, d, r);
      check({d[29:0], r}, 32'h2);
      host.wr(12'h3FC, 8'hFF, 4'hF, r);
      check(32'(r), 32'h2);
   endtask
   task automatic t_events;
      logic [3:0] m [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
      foreach (m[i])
      begin
         pulse(m[i]);
         rd_chk(12'h38C, {4'h0, m[i]});
         rd_chk(12'h38C, 8'h00);
      end
   endtask
   // sweep the clearing read across the event edge; k = 1 makes them meet and the set must win
   task automatic t_set_wins;
      logic [31:0] first;
      for (int k = 0; k < 6; k++)
      begin
         fork
            begin
               ev <= 4'h1;
               repeat (3) @(posedge clk);
               ev <= 4'h0;
            end
            begin
               repeat (k) @(posedge clk);
               host.rd(12'h38C, first, r);
            end
         join
         repeat (6) @(posedge clk);
         host.rd(12'h38C, d, r);
         check(32'(first[0] | d[0]), 32'h1);
      end
   endtask
   task automatic t_regs;
      wr_ok(12'h394, 8'hFF);
      rd_chk(12'h394, 8'hFC);
      check(32'({gblk, rsm}), 32'h3F);
      wr_ok(12'h394, 8'h54);
      // the pins follow the register one edge after the write lands
      @(posedge clk);
      check(32'({gblk, rsm}), 32'h15);
      wr_ok(12'h398, 8'hFF);
      rd_chk(12'h398, 8'h9E);
      check(32'(msel), 32'h1);
      host.wr(12'h398, 8'h00, 4'h0, r);
      check(32'(r), 32'h0);
      rd_chk(12'h398, 8'h9E);
      wr_ok(12'h398, 8'h00);
      rd_chk(12'h398, 8'h00);
      check(32'(n_clr), 32'h1);
      wr_ok(12'h390, 8'h08);
      rd_chk(12'h390, 8'h08);
      check(32'(any_key), 32'h1);
   endtask
   task automatic t_hunt;
      wr_ok(12'h390, 8'h0C);
      pulse(4'h2);
      check(32'(n_wake), 32'h1);
      rd_chk(12'h390, 8'h08);
      pulse(4'h4);
      check(32'(n_wake), 32'h1);
      rd_chk(12'h38C, 8'h06);
      wr_ok(12'h390, 8'h8C);
      bus_rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      bus_rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(12'h390, 8'h80);
   endtask
   task automatic t_policy;
      logic e;
      int   n0;
      wr_ok(12'h398, 8'h10);
      for (int p = 0; p < 4; p++)
      begin
         e = (p == 1 || p == 2);
         n0 = n_rec;
         wr_ok(12'h390, 8'h80 | 8'(p << 5));
         power_loss;
         check(32'(n_rec - n0), 32'(e));
         rd_chk(12'h38C, {3'h0, !e, 4'h0});
      end
      // leave the outcome bit set, then disable recovery: the bit must read zero
      wr_ok(12'h390, 8'h80);
      power_loss;
      n0 = n_rec;
      wr_ok(12'h390, 8'h20);
      power_loss;
      check(32'(n_rec - n0), 32'h0);
      rd_chk(12'h38C, 8'h00);
   endtask
   task automatic stop_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      {rst_n, bus_rst_n, stby, pfail, syson, ev} = 9'h090;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_events;
      t_set_wins;
      t_regs;
      t_hunt;
      t_policy;
      stop_test;
   end
   // whole run needs well under 3000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test;
   end
endmodule
`default_nettype wire
